// *** hdl/tccu_edge_det.sv ***
`timescale 1ns/1ps
module tccu_edge_det
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Edge selection and result.
    tccu_edge_if.det eif
);
    logic prev_ff;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            prev_ff <= 1'b0;
        else if (ce_i)
            prev_ff <= eif.pin;
    end

    // Dual-edge overrides the single-edge polarity.
    always_comb
    begin
        if (eif.dual)
            eif.edge_hit = prev_ff ^ eif.pin;
        else if (eif.pol)
            eif.edge_hit = !prev_ff && eif.pin;
        else
            eif.edge_hit = prev_ff && !eif.pin;
    end
endmodule

// *** hdl/tccu_edge_if.sv ***
`timescale 1ns/1ps
interface tccu_edge_if;
    logic pin;
    logic pol;
    logic dual;
    logic edge_hit;
    modport det (input pin, input pol, input dual, output edge_hit);
    modport user (output pin, output pol, output dual, input edge_hit);
endinterface

// *** hdl/tccu_pkg.sv ***
package tccu_pkg;

    // Register indices on the plain register port (byte registers, 8-bit data).
    localparam logic [3:0] ADDR_CNT_HI = 4'h0;
    localparam logic [3:0] ADDR_CNT_LO = 4'h1;
    localparam logic [3:0] ADDR_RLD_HI = 4'h2;
    localparam logic [3:0] ADDR_RLD_LO = 4'h3;
    localparam logic [3:0] ADDR_PA_HI = 4'h4;
    localparam logic [3:0] ADDR_PA_LO = 4'h5;
    localparam logic [3:0] ADDR_CTL0 = 4'h6;
    localparam logic [3:0] ADDR_CTL1 = 4'h7;
    localparam logic [3:0] ADDR_PB_HI = 4'h8;
    localparam logic [3:0] ADDR_PB_LO = 4'h9;
    localparam logic [3:0] ADDR_CTL2 = 4'hA;

    // Control 0 fields.
    localparam int CTL0_MODE_EXT_BIT = 7;
    localparam int CTL0_IRQ_CFG_LSB = 5;
    localparam int CTL0_CAUSE_BIT = 0;

    // Control 1 fields.
    localparam int CTL1_EN_BIT = 7;
    localparam int CTL1_POL_BIT = 6;
    localparam int CTL1_PRES_LSB = 3;
    localparam int CTL1_MODE_LSB = 0;

    // Control 2 fields.
    localparam int CTL2_DUAL_BIT = 4;

    // Reset values.
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0001;
    localparam logic [15:0] RLD_RESET = 16'hFFFF;
    localparam logic [15:0] RESTART_COUNT = 16'h0001;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // Interrupt cause configuration codes.
    localparam logic [1:0] IRQ_CFG_BOTH = 2'h0;
    localparam logic [1:0] IRQ_CFG_CAPT = 2'h2;
    localparam logic [1:0] IRQ_CFG_RELOAD = 2'h3;

    // Mode codes formed from the extension bit and the 3-bit mode field.
    typedef enum logic [3:0] {
        TCCU_MODE_PWM = 4'h3,
        TCCU_MODE_CAPTURE = 4'h4,
        TCCU_MODE_CAPCMP = 4'h7,
        TCCU_MODE_DEMOD = 4'hC
    } tccu_mode_t;

endpackage

// *** hdl/tccu_top.sv ***
// Overview of operation
// - PWM high fraction is (reload-compare)/reload, or compare/reload when polarity set.
// - Capture mode copies the count into pair A on the selected edge.
// - Capture mode counts timer clocks up to the 16-bit reload value.
// - Input polarity bit picks rising or falling capture edge.
// - Capture event interrupts, counting goes on, cause flag set.
// - Reaching reload in capture mode interrupts, keeps counting, clears cause flag.
// - Capture/compare mode waits for the first selected edge before counting.
// - Capture/compare edges after the first store the count into pair A.
// - Capture/compare capture interrupts, reloads 0001H, resumes, sets cause flag.
// - Capture/compare compare match interrupts, reloads 0001H, resumes, clears cause flag.
// - Interrupt fires on both events by default; config field restricts it.
// - Demodulation dual-edge bit captures both edges, ignoring the polarity bit.
// - Demodulation counting starts only at the first selected edge (any transition when dual-edge set).
// - Count reads while running do not disturb the timer.
// - High-byte read while enabled latches low byte for the next low read.
// - Low-byte read while disabled returns the live count.
`timescale 1ns/1ps
module tccu_top
    import tccu_pkg::*;
#(
    parameter int PRES_W = 3
)
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Timer pins and events.
    input wire logic tin_i,
    output logic pwm_o,
    output logic irq_o
);
    logic [15:0] cnt_ff;
    logic [15:0] rld_ff;
    logic [15:0] pa_ff;
    logic [15:0] pb_ff;
    logic [7:0] ctl0_ff;
    logic [7:0] ctl1_ff;
    logic [7:0] ctl2_ff;
    logic [7:0] hold_ff;
    logic [7:0] rdata_ff;
    logic [6:0] pres_cnt_ff;
    logic armed_ff;
    logic live;
    logic pwm_ff;
    logic irq_ff;
    logic [6:0] pres_div;
    logic tick;
    logic enabled;
    logic [3:0] mode_code;
    logic is_capt;
    logic is_capcmp;
    logic is_demod;
    logic is_pwm;
    logic edge_hit;
    logic capt_ev;
    logic rld_ev;
    logic start_ev;
    logic wr_ctl0;
    logic [15:0] nxt_cnt;

    tccu_edge_if eif();

    assign eif.pin = tin_i;
    assign eif.pol = ctl1_ff[CTL1_POL_BIT];
    assign eif.dual = is_demod && ctl2_ff[CTL2_DUAL_BIT];
    assign edge_hit = eif.edge_hit;

    tccu_edge_det u_edge
    (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .eif(eif)
    );

    assign enabled = ctl1_ff[CTL1_EN_BIT];
    assign mode_code = {ctl0_ff[CTL0_MODE_EXT_BIT], ctl1_ff[CTL1_MODE_LSB +: 3]};
    assign is_capt = mode_code == TCCU_MODE_CAPTURE;
    assign is_capcmp = mode_code == TCCU_MODE_CAPCMP;
    assign is_demod = mode_code == TCCU_MODE_DEMOD;
    assign is_pwm = mode_code == TCCU_MODE_PWM;

    // Prescale divides by 2 to the power of the field.
    assign pres_div = 7'(7'h01 << ctl1_ff[CTL1_PRES_LSB +: PRES_W]);
    // Modes that wait for a first edge run only once armed; others run at once.
    assign live = armed_ff || !(is_capcmp || is_demod);
    assign tick = enabled && live && (pres_cnt_ff == 7'(pres_div - 7'h01));

    // Input edges: the first one arms capture/compare and demodulation.
    assign start_ev = enabled && !armed_ff && edge_hit && (is_capcmp || is_demod);
    assign capt_ev = enabled && live && edge_hit && (is_capt || is_capcmp || is_demod);
    assign rld_ev = tick && (cnt_ff == rld_ff) && !capt_ev;
    assign wr_ctl0 = wr_i && addr_i == ADDR_CTL0;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            armed_ff <= 1'b0;
        else if (ce_i)
        begin
            if (!enabled)
                armed_ff <= 1'b0;
            else if (start_ev)
                armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pres_cnt_ff <= 7'h00;
        else if (ce_i)
        begin
            if (!enabled || tick || !live)
                pres_cnt_ff <= 7'h00;
            else
                pres_cnt_ff <= 7'(pres_cnt_ff + 7'h01);
        end
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (capt_ev && (is_capcmp || is_demod))
            nxt_cnt = RESTART_COUNT;
        else if (rld_ev)
            nxt_cnt = RESTART_COUNT;
        else if (tick)
            nxt_cnt = 16'(cnt_ff + 16'h0001);
    end

    // Counter: software writes only take hold while disabled.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            cnt_ff <= CNT_RESET;
        else if (ce_i)
        begin
            if (wr_i && !enabled && addr_i == ADDR_CNT_HI)
                cnt_ff[15:8] <= wdata_i;
            else if (wr_i && !enabled && addr_i == ADDR_CNT_LO)
                cnt_ff[7:0] <= wdata_i;
            else
                cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rld_ff <= RLD_RESET;
        else if (ce_i && wr_i)
        begin
            if (addr_i == ADDR_RLD_HI)
                rld_ff[15:8] <= wdata_i;
            else if (addr_i == ADDR_RLD_LO)
                rld_ff[7:0] <= wdata_i;
        end
    end

    // Capture pair A takes the count; a capture wins over a software write.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pa_ff <= ZERO16;
        else if (ce_i)
        begin
            if (capt_ev)
                pa_ff <= cnt_ff;
            else if (wr_i && addr_i == ADDR_PA_HI)
                pa_ff[15:8] <= wdata_i;
            else if (wr_i && addr_i == ADDR_PA_LO)
                pa_ff[7:0] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pb_ff <= ZERO16;
        else if (ce_i && wr_i)
        begin
            if (addr_i == ADDR_PB_HI)
                pb_ff[15:8] <= wdata_i;
            else if (addr_i == ADDR_PB_LO)
                pb_ff[7:0] <= wdata_i;
        end
    end

    // Control 0: the cause flag is hardware owned; events win over writes.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctl0_ff <= CTL_RESET;
        else if (ce_i)
        begin
            if (wr_ctl0)
                ctl0_ff[7:1] <= wdata_i[7:1];
            if (capt_ev)
                ctl0_ff[CTL0_CAUSE_BIT] <= 1'b1;
            else if (rld_ev)
                ctl0_ff[CTL0_CAUSE_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctl1_ff <= CTL_RESET;
        else if (ce_i && wr_i && addr_i == ADDR_CTL1)
            ctl1_ff <= wdata_i;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctl2_ff <= CTL_RESET;
        else if (ce_i && wr_i && addr_i == ADDR_CTL2)
            ctl2_ff <= wdata_i;
    end

    // Interrupt pulse, filtered by the cause configuration field.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            irq_ff <= 1'b0;
        else if (ce_i)
        begin
            unique case (ctl0_ff[CTL0_IRQ_CFG_LSB +: 2])
                IRQ_CFG_CAPT: irq_ff <= capt_ev;
                IRQ_CFG_RELOAD: irq_ff <= rld_ev;
                default: irq_ff <= capt_ev || rld_ev;
            endcase
        end
    end

    // PWM output level compares the count against pair A.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pwm_ff <= 1'b0;
        else if (ce_i)
        begin
            if (!(enabled && is_pwm))
                pwm_ff <= 1'b0;
            else if (ctl1_ff[CTL1_POL_BIT])
                pwm_ff <= cnt_ff <= pa_ff;
            else
                pwm_ff <= cnt_ff > pa_ff;
        end
    end

    // High byte read while enabled freezes the low byte for the next low read.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            hold_ff <= 8'h00;
        else if (ce_i && rd_i && enabled && addr_i == ADDR_CNT_HI)
            hold_ff <= cnt_ff[7:0];
    end

    // Reads have no side effect on counting.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_ff <= 8'h00;
        else if (ce_i)
        begin
            if (!rd_i)
                rdata_ff <= 8'h00;
            else
            begin
                unique case (addr_i)
                    ADDR_CNT_HI: rdata_ff <= cnt_ff[15:8];
                    ADDR_CNT_LO: rdata_ff <= enabled ? hold_ff : cnt_ff[7:0];
                    ADDR_RLD_HI: rdata_ff <= rld_ff[15:8];
                    ADDR_RLD_LO: rdata_ff <= rld_ff[7:0];
                    ADDR_PA_HI: rdata_ff <= pa_ff[15:8];
                    ADDR_PA_LO: rdata_ff <= pa_ff[7:0];
                    ADDR_CTL0: rdata_ff <= ctl0_ff;
                    ADDR_CTL1: rdata_ff <= ctl1_ff;
                    ADDR_PB_HI: rdata_ff <= pb_ff[15:8];
                    ADDR_PB_LO: rdata_ff <= pb_ff[7:0];
                    ADDR_CTL2: rdata_ff <= ctl2_ff;
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o = rdata_ff;
    assign pwm_o = pwm_ff;
    assign irq_o = irq_ff;
endmodule

// *** sim/tccu_checker.sv ***
`timescale 1ns/1ps
module tccu_checker
    import tccu_pkg::*;
#(
    parameter int PRES_W = 3
)
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Register port.
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    // Timer pins and events.
    input wire logic tin_i,
    input wire logic pwm_o,
    input wire logic irq_o
);
    logic [7:0] ctl0_ff;
    logic [7:0] ctl1_ff;
    logic tin_ff;
    logic arm_ff;
    // Shadow control bits; only undivided running counts are judged.
    wire logic run = ce_i && ctl1_ff[CTL1_EN_BIT] && ctl1_ff[5:3] == 3'h0;
    wire logic capt = run && {ctl0_ff[7], ctl1_ff[2:0]} == TCCU_MODE_CAPTURE;
    wire logic cmp = run && {ctl0_ff[7], ctl1_ff[2:0]} == TCCU_MODE_CAPCMP;
    wire logic sel = ctl1_ff[CTL1_POL_BIT] ? (tin_i & ~tin_ff) : (~tin_i & tin_ff);
    wire logic wrong = (tin_i ^ tin_ff) & ~sel;
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctl0_ff <= CTL_RESET;
            ctl1_ff <= CTL_RESET;
            tin_ff <= 1'b0;
            arm_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            if (wr_i && addr_i == ADDR_CTL0)
                ctl0_ff <= wdata_i;
            if (wr_i && addr_i == ADDR_CTL1)
                ctl1_ff <= wdata_i;
            tin_ff <= tin_i;
            arm_ff <= ctl1_ff[CTL1_EN_BIT] && (arm_ff || (cmp && sel));
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_capture;
        capt && sel && ctl0_ff[6:5] != IRQ_CFG_RELOAD;
    endsequence
    sequence s_second_edge;
        cmp && arm_ff && sel;
    endsequence
    a_capture_irq: assert property (s_capture |=> irq_o)
        else $error("capture edge without interrupt");
    a_wrong_edge_quiet: assert property (capt && wrong && ctl0_ff[6:5] == IRQ_CFG_CAPT |=> !irq_o)
        else $error("wrong edge raised interrupt");
    a_reload_only_quiet: assert property (capt && sel && ctl0_ff[6:5] == IRQ_CFG_RELOAD |=> !irq_o)
        else $error("masked capture raised interrupt");
    a_first_edge_quiet: assert property (cmp && !arm_ff && sel |=> !irq_o)
        else $error("first edge raised interrupt");
    a_capcmp_irq: assert property (s_second_edge |=> irq_o)
        else $error("later edge without interrupt");
    a_irq_single: assert property (irq_o && ce_i |=> !irq_o)
        else $error("interrupt longer than one cycle");
    a_ce_freeze: assert property (!ce_i && !irq_o |=> !irq_o)
        else $error("interrupt while clock enable low");
    a_read_idle: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data without read");
endmodule
bind tccu_top tccu_checker #(.PRES_W(PRES_W)) chk_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .tin_i(tin_i), .pwm_o(pwm_o), .irq_o(irq_o));

// *** sim/tccu_src.sv ***
`timescale 1ns/1ps
module tccu_src
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Requested level and driven pin.
    input wire logic lvl_i,
    output logic tin_o
);
    // The pin moves one clock after a request, always just after an edge.
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            tin_o <= 1'b0;
        else
            tin_o <= lvl_i;
    end
endmodule

// *** sim/timer_capture_compare_unit_test.sv ***
`timescale 1ns/1ps
module timer_capture_compare_unit_test;
    import tccu_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic lvl = 1'b0;
    logic tin_i;
    logic pwm_o;
    logic irq_o;
    logic [7:0] rdata_o;
    logic [7:0] b;
    logic [15:0] v;
    logic [1:0] c;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int irqs = 0;
    int n;
    int t0;
    int t1;
    int tc;
    always #2 clk_i = ~clk_i;
    tccu_src src_u (.clk_i(clk_i), .rstn_i(rstn_i), .lvl_i(lvl), .tin_o(tin_i));
    tccu_top #(.PRES_W(3)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .tin_i(tin_i), .pwm_o(pwm_o), .irq_o(irq_o));
    task automatic results();
        if (fail_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (irq_o === 1'b1)
            irqs <= irqs + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // Counts taken against bench time may land two clocks either side.
    task automatic near(input string s, input int e, input logic [15:0] g);
        chk(s, ((g - e[15:0] + 16'h0002) <= 16'h0004) === 1'b1 ? g : e[15:0], g);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] r);
        rd(a, r[15:8]);
        rd(a + 4'h1, r[7:0]);
    endtask
    task automatic setup(input logic [7:0] c0, input logic [15:0] rl);
        wr(ADDR_CTL1, 8'h00);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CNT_LO, 8'h01);
        wr(ADDR_RLD_HI, rl[15:8]);
        wr(ADDR_RLD_LO, rl[7:0]);
        wr(ADDR_CTL0, c0);
    endtask
    task automatic go(input logic [7:0] c1);
        wr(ADDR_CTL1, c1);
        t0 = cyc;
    endtask
    task automatic pin(input logic l, input int w);
        @(posedge clk_i);
        lvl <= l;
        t1 = cyc;
        repeat (w) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        ce_i <= 1'b1;
        rd(4'hF, b);
        chk("unmapped", 16'h0000, {8'h00, b});
        rd16(ADDR_CNT_HI, v);
        chk("reset count", CNT_RESET, v);
        for (int i = 0; i < 4; i++)
        begin
            c = i == 1 ? IRQ_CFG_CAPT : i == 2 ? IRQ_CFG_RELOAD : IRQ_CFG_BOTH;
            n = irqs;
            setup({1'b0, c, 5'h00}, 16'h0100);
            go(i == 3 ? 8'h84 : 8'hC4);
            pin(1'b1, 20);
            tc = t1;
            pin(1'b0, 10);
            if (i == 3)
                tc = t1;
            rd16(ADDR_PA_HI, v);
            near("capture", 1 + tc - t0, v);
            rd(ADDR_CTL0, b);
            chk("cause set", {8'h00, 1'b0, c, 5'h01}, {8'h00, b});
            repeat (300) @(posedge clk_i);
            rd(ADDR_CTL0, b);
            chk("cause clear", {8'h00, 1'b0, c, 5'h00}, {8'h00, b});
            tc = 2 - (c == IRQ_CFG_RELOAD) - (c == IRQ_CFG_CAPT);
            chk("irq count", 16'(tc), 16'(irqs - n));
        end
        setup(8'h00, 16'h0100);
        n = irqs;
        go(8'hC7);
        repeat (300) @(posedge clk_i);
        rd16(ADDR_CNT_HI, v);
        chk("idle count", 16'h0001, v);
        pin(1'b1, 30);
        t0 = t1;
        pin(1'b0, 10);
        pin(1'b1, 10);
        tc = t1;
        rd16(ADDR_PA_HI, v);
        near("capcmp capture", 1 + tc - t0, v);
        t1 = cyc;
        rd16(ADDR_CNT_HI, v);
        near("restart count", t1 - tc, v);
        rd(ADDR_CTL0, b);
        chk("capcmp cause", 16'h0001, {8'h00, b});
        repeat (300) @(posedge clk_i);
        rd(ADDR_CTL0, b);
        chk("compare cause", 16'h0000, {8'h00, b});
        chk("capcmp irqs", 16'h0002, 16'(irqs - n));
        setup(8'h00, 16'hFFFF);
        go(8'h9C);
        repeat (400) @(posedge clk_i);
        t1 = cyc;
        rd(ADDR_CNT_HI, v[15:8]);
        repeat (300) @(posedge clk_i);
        rd(ADDR_CNT_LO, v[7:0]);
        near("held count", 1 + (t1 - t0) / 8, v);
        @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (80) @(posedge clk_i);
        ce_i <= 1'b1;
        wr(ADDR_CTL1, 8'h1C);
        t1 = cyc;
        rd16(ADDR_CNT_HI, v);
        near("live count", 1 + (t1 - t0 - 80) / 8, v);
        for (int p = 0; p < 2; p++)
        begin
            setup(8'h00, 16'h0010);
            wr(ADDR_PA_HI, 8'h00);
            wr(ADDR_PA_LO, 8'h04);
            go(p == 1 ? 8'hC3 : 8'h83);
            repeat (40) @(posedge clk_i);
            n = 0;
            repeat (160) @(posedge clk_i) n += (pwm_o === 1'b1);
            chk("pwm high", p == 1 ? 16'h0028 : 16'h0078, 16'(n));
        end
        setup(8'h80, 16'hFFFF);
        wr(ADDR_CTL2, 8'h10);
        wr(ADDR_PA_HI, 8'h00);
        wr(ADDR_PA_LO, 8'h00);
        wr(ADDR_PB_HI, 8'h00);
        wr(ADDR_PB_LO, 8'h00);
        n = irqs;
        go(8'h84);
        repeat (20) @(posedge clk_i);
        rd16(ADDR_CNT_HI, v);
        chk("demod idle", 16'h0001, v);
        pin(1'b0, 20);
        t0 = t1;
        pin(1'b1, 10);
        tc = t1;
        rd16(ADDR_PA_HI, v);
        near("demod capture", 1 + tc - t0, v);
        chk("demod irqs", 16'h0001, 16'(irqs - n));
        results();
    end
endmodule
